// >>> hw/tsr_map.svh
`ifndef TSR_MAP_SVH
`define TSR_MAP_SVH

// register addresses of the readback window
`define TSR_ADDR_CHAN_SEL 8'h63
`define TSR_ADDR_USE_HI 8'h64
`define TSR_ADDR_USE_LO 8'h65
`define TSR_ADDR_AVG_HI 8'h66
`define TSR_ADDR_AVG_LO 8'h67
`define TSR_ADDR_DIF_HI 8'h68
`define TSR_ADDR_DIF_LO 8'h69
`define TSR_ADDR_DAC_HI 8'h6a
`define TSR_ADDR_DAC_LO 8'h6b

// selector field
`define TSR_SEL_MSB 3
`define TSR_SEL_RESET 4'h0
`define TSR_SEL_LAST_BUTTON 4'h7
`define TSR_SEL_PROX 4'h8
`define TSR_NUM_CHAN 9

`endif

// >>> hw/tsr_pkg.sv
package tsr_pkg;
   typedef logic [15:0] tsr_word_t;
   typedef logic [3:0] tsr_sel_t;
   typedef logic [7:0] tsr_byte_t;
endpackage

// >>> hw/tsr_readback.sv
`timescale 1ns/1ps
`include "tsr_map.svh"

module tsr_readback
   import tsr_pkg::*;
(
   input wire logic clk_sys_i,
   input wire logic reset_i,
   input wire logic clk_en_i,
   // byte access port from the serial slave
   input wire logic addr_load_i,
   input wire logic [7:0] addr_i,
   input wire logic wr_i,
   input wire logic [7:0] wdata_i,
   input wire logic rd_i,
   output logic [7:0] rdata_o,
   // channel data from the sensing engine, channel c at [16c+:16]
   input wire logic [143:0] useful_value_i,
   input wire logic [143:0] averaged_value_i,
   input wire logic [143:0] difference_value_i,
   input wire logic [143:0] offset_dac_code_i,
   // manual dac override toward the engine
   output logic dac_load_o,
   output logic [3:0] dac_chan_o,
   output logic [15:0] dac_code_o
);

   ////////////////////////////////////////////////////////////////////////
   // pointer advance; runs past the map and wraps from 8'hff to 8'h00
   function automatic tsr_byte_t bump(input tsr_byte_t a);
      tsr_byte_t r;
      r = a + 8'h01;
      return r;
   endfunction

   // channel slice of a packed bus; codes above proximity read zero
   function automatic tsr_word_t pick(input logic [143:0] v,
                                      input tsr_sel_t s);
      tsr_word_t r;
      r = 16'h0000;
      if (s <= `TSR_SEL_PROX) begin
         r = v[16 * s +: 16];
      end
      return r;
   endfunction

   function automatic tsr_byte_t half(input tsr_word_t w,
                                      input logic low);
      tsr_byte_t r;
      r = w[15:8];
      if (low) begin
         r = w[7:0];
      end
      return r;
   endfunction

   function automatic logic hits(input tsr_byte_t a,
                                 input tsr_byte_t target);
      logic r;
      r = (a == target);
      return r;
   endfunction

   function automatic logic in_pair(input tsr_byte_t a,
                                    input tsr_byte_t hi_addr,
                                    input tsr_byte_t lo_addr);
      logic r;
      r = hits(a, hi_addr) || hits(a, lo_addr);
      return r;
   endfunction

   ////////////////////////////////////////////////////////////////////////
   // state
   tsr_byte_t addr_reg;
   tsr_byte_t addr_next;

   tsr_sel_t sel_reg;
   tsr_sel_t sel_next;

   tsr_byte_t dac_hi_reg;
   tsr_byte_t dac_hi_next;

   logic load_reg;
   logic load_next;
   tsr_sel_t lchan_reg;
   tsr_sel_t lchan_next;
   tsr_word_t code_reg;
   tsr_word_t code_next;

   tsr_byte_t rdata_reg;
   tsr_byte_t rdata_next;

   ////////////////////////////////////////////////////////////////////////
   // access qualification
   logic take_wr;
   logic take_rd;
   logic take_any;
   tsr_byte_t acc_addr;

   always_comb begin
      take_wr = clk_en_i & wr_i;
      // a colliding read is dropped so a write never goes missing
      take_rd = clk_en_i & rd_i & ~wr_i;
      take_any = take_wr | take_rd;
      if (addr_load_i) begin
         acc_addr = addr_i;
      end else begin
         acc_addr = addr_reg;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // address classes, shared by the read and write paths
   logic at_sel;
   logic at_use;
   logic at_avg;
   logic at_dif;
   logic at_dac;
   logic at_dac_hi;
   logic at_dac_lo;
   logic at_low_half;

   always_comb begin
      at_sel = hits(acc_addr, `TSR_ADDR_CHAN_SEL);
      at_use = in_pair(acc_addr, `TSR_ADDR_USE_HI, `TSR_ADDR_USE_LO);
      at_avg = in_pair(acc_addr, `TSR_ADDR_AVG_HI, `TSR_ADDR_AVG_LO);
      at_dif = in_pair(acc_addr, `TSR_ADDR_DIF_HI, `TSR_ADDR_DIF_LO);
      at_dac = in_pair(acc_addr, `TSR_ADDR_DAC_HI, `TSR_ADDR_DAC_LO);
      at_dac_hi = hits(acc_addr, `TSR_ADDR_DAC_HI);
      at_dac_lo = hits(acc_addr, `TSR_ADDR_DAC_LO);
      // every low byte sits at the odd address of its pair
      at_low_half = acc_addr[0];
   end

   ////////////////////////////////////////////////////////////////////////
   // live channel data, resampled on every read
   tsr_word_t use_w;
   tsr_word_t avg_w;
   tsr_word_t dif_w;
   tsr_word_t dac_w;

   always_comb begin
      use_w = pick(useful_value_i, sel_reg);
      avg_w = pick(averaged_value_i, sel_reg);
      dif_w = pick(difference_value_i, sel_reg);
      // engine value, not the last override
      dac_w = pick(offset_dac_code_i, sel_reg);
   end

   ////////////////////////////////////////////////////////////////////////
   // write strobes
   logic wr_sel;
   logic wr_dac_hi;
   logic wr_dac_lo;

   always_comb begin
      wr_sel = 1'b0;
      wr_dac_hi = 1'b0;
      wr_dac_lo = 1'b0;
      if (take_wr) begin
         // the useful, averaged and difference words ignore writes
         if (at_sel) begin
            wr_sel = 1'b1;
         end else if (at_dac_hi) begin
            wr_dac_hi = 1'b1;
         end else if (at_dac_lo) begin
            wr_dac_lo = 1'b1;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // address pointer
   always_comb begin
      addr_next = addr_reg;
      if (addr_load_i) begin
         addr_next = addr_i;
      end
      if (take_any) begin
         addr_next = bump(acc_addr);
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (reset_i) begin
         addr_reg <= 8'h00;
      end else if (clk_en_i) begin
         addr_reg <= addr_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // channel selector; writable so software can steer the window
   always_comb begin
      sel_next = sel_reg;
      if (wr_sel) begin
         // upper nibble dropped here, so it always reads zero
         sel_next = wdata_i[`TSR_SEL_MSB:0];
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (reset_i) begin
         sel_reg <= `TSR_SEL_RESET;
      end else if (clk_en_i) begin
         sel_reg <= sel_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // held high byte of the dac code
   always_comb begin
      dac_hi_next = dac_hi_reg;
      if (wr_dac_hi) begin
         dac_hi_next = wdata_i;
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (reset_i) begin
         dac_hi_reg <= 8'h00;
      end else if (clk_en_i) begin
         dac_hi_reg <= dac_hi_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // override commit toward the engine
   always_comb begin
      load_next = 1'b0;
      lchan_next = lchan_reg;
      code_next = code_reg;
      // only the low byte commits, so a lone high byte stays pending
      if (wr_dac_lo) begin
         load_next = 1'b1;
         lchan_next = sel_reg;
         code_next = {dac_hi_reg, wdata_i};
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (reset_i) begin
         load_reg <= 1'b0;
         lchan_reg <= 4'h0;
         code_reg <= 16'h0000;
      end else if (clk_en_i) begin
         load_reg <= load_next;
         lchan_reg <= lchan_next;
         code_reg <= code_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // read data, held until the next read
   always_comb begin
      rdata_next = rdata_reg;
      if (take_rd) begin
         if (at_sel) begin
            rdata_next = {4'h0, sel_reg};
         end else if (at_use) begin
            rdata_next = half(use_w, at_low_half);
         end else if (at_avg) begin
            rdata_next = half(avg_w, at_low_half);
         end else if (at_dif) begin
            rdata_next = half(dif_w, at_low_half);
         end else if (at_dac) begin
            rdata_next = half(dac_w, at_low_half);
         end else begin
            rdata_next = 8'h00;
         end
      end
   end

   always_ff @(posedge clk_sys_i) begin
      if (reset_i) begin
         rdata_reg <= 8'h00;
      end else if (clk_en_i) begin
         rdata_reg <= rdata_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // outputs straight from the registers
   assign rdata_o = rdata_reg;
   assign dac_load_o = load_reg;
   assign dac_chan_o = lchan_reg;
   assign dac_code_o = code_reg;

endmodule

// >>> bench/tsr_readback_checker.sv
`timescale 1ns/1ps
module tsr_checker (
   input wire logic clk_sys_i,
   input wire logic reset_i,
   input wire logic clk_en_i,
   input wire logic addr_load_i,
   input wire logic [7:0] addr_i,
   input wire logic wr_i,
   input wire logic [7:0] wdata_i,
   input wire logic rd_i,
   input wire logic [7:0] rdata_o,
   input wire logic dac_load_o,
   input wire logic [15:0] dac_code_o
);
   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (reset_i);
   wire w = wr_i && clk_en_i && addr_load_i;
   wire r = rd_i && clk_en_i && !wr_i && addr_load_i;
   commit_a: assert property (w && addr_i == 8'h6b |=> dac_load_o)
      else $error("no commit");
   code_low_a: assert property (w && addr_i == 8'h6b |=>
      dac_code_o[7:0] == $past(wdata_i)) else $error("bad code");
   no_commit_a: assert property (w && addr_i != 8'h6b |=> !dac_load_o)
      else $error("stray commit");
   code_hold_a: assert property ($changed(dac_code_o) |-> dac_load_o)
      else $error("code moved");
   rdata_hold_a: assert property (!(rd_i && clk_en_i && !wr_i) |=>
      $stable(rdata_o)) else $error("rdata moved");
   sel_rsvd_a: assert property (r && addr_i == 8'h63 |=>
      rdata_o[7:4] == 4'h0) else $error("reserved set");
   unmapped_a: assert property (r && addr_i == 8'h70 |=>
      rdata_o == 8'h00) else $error("unmapped read");
   sel_echo_a: assert property (w && addr_i == 8'h63 ##1 r &&
      addr_i == 8'h63 |=> rdata_o[3:0] == $past(wdata_i[3:0], 2))
      else $error("bad selector");
endmodule
bind tsr_readback tsr_checker tsr_checker_i (.*);

// >>> bench/tsr_readback_bench.sv
`timescale 1ns/1ps
`define CHK(x, y) begin tests_run++; if ((x) !== (y)) begin errors++; \
$display("MISMATCH %0t %h %h", $time, x, y); end end
module tsr_readback_bench;
   logic clk_sys_i, reset_i, clk_en_i, addr_load_i, wr_i, rd_i, pend, pcm;
   logic dac_load_o;
   logic [7:0] addr_i, wdata_i, rdata_o, ptr, pexp, hi, lo, x;
   logic [3:0] sel, dac_chan_o;
   logic [15:0] dac_code_o;
   logic [143:0] dv [4];
   int errors, tests_run, seed, s, i;
   tsr_readback tsr_readback_i (.*, .useful_value_i(dv[0]),
      .averaged_value_i(dv[1]), .difference_value_i(dv[2]),
      .offset_dac_code_i(dv[3]));
   initial begin
      clk_sys_i = 0;
      forever #5 clk_sys_i = ~clk_sys_i;
   end
   ////////////////////////////////////////////////////////////////////
   function automatic logic [7:0] ex(input logic [7:0] a);
      logic [15:0] q;
      q = 16'h0000;
      if (a == 8'h63) return {4'h0, sel};
      if (a >= 8'h64 && a <= 8'h6b && sel < 4'h9)
         q = dv[(a - 8'h64) >> 1][16 * sel +: 16];
      return a[0] ? q[7:0] : q[15:8];
   endfunction
   task op(input logic ld, input logic [7:0] a, input logic w,
      input logic r, input logic [7:0] d8);
      @(posedge clk_sys_i);
      addr_load_i <= ld;
      addr_i <= a;
      wr_i <= w;
      rd_i <= r;
      wdata_i <= d8;
      @(negedge clk_sys_i);
      if (pend) `CHK(rdata_o, pexp)
      `CHK(dac_load_o, pcm)
      if (pcm) `CHK({dac_chan_o, dac_code_o}, {sel, hi, lo})
      x = ld ? a : ptr;
      pend = r && !w;
      pexp = ex(x);
      pcm = w && x == 8'h6b;
      if (w && x == 8'h63) sel = d8[3:0];
      if (w && x == 8'h6a) hi = d8;
      if (pcm) lo = d8;
      if (w || r) ptr = x + 8'h01;
   endtask
   task test_done;
      if (errors == 0 && tests_run > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   initial begin
      {reset_i, clk_en_i, addr_load_i, wr_i, rd_i} = 5'h18;
      {addr_i, wdata_i, ptr, sel, pend, pcm} = '0;
      foreach (dv[i]) dv[i] = '0;
      seed = 94217;
      repeat (8) @(posedge clk_sys_i);
      reset_i <= 0;
      for (s = 0; s < 11; s++) begin
         @(posedge clk_sys_i);
         for (i = 0; i < 36; i++) dv[i / 9][16 * (i % 9) +: 16] <= $random(seed);
         if (s == 4) begin
            clk_en_i <= 0;
            repeat (3) @(posedge clk_sys_i);
            clk_en_i <= 1;
         end
         op(1, 8'h63, 1, 0, {4'ha, s == 10 ? 4'hf : 4'(s)});
         op(1, 8'h63, 0, 1, 8'h00);
         repeat (9) op(0, 8'h00, 0, 1, 8'h00);
         op(1, 8'h64, 1, 0, 8'($random(seed)));
         if (s < 9) op(1, 8'h6a, 1, 0, 8'($random(seed)));
         if (s < 9) op(0, 8'h00, 1, 1, 8'($random(seed)));
         op(1, 8'h70, 0, 1, 8'h00);
      end
      op(0, 8'h00, 0, 0, 8'h00);
      test_done;
   end
endmodule
